// ===== design/irq_pkg.sv
// Package with register map, field positions, reset values and carrier types of the interrupt enable/flag unit.
// Overview of operation
// - Every flag sets on its event regardless of its enable or the global enable.
// - Global enable bit 7 lets unmasked sources interrupt; zero blocks all interrupts.
// - Peripheral-group enable bit 6 must be set for any peripheral source to interrupt.
// - Control bit 5 enables the timer 0 overflow interrupt.
// - Control bit 4 enables the external edge-pin interrupt.
// - Control bit 3 enables port change; per-pin change enables must also be set.
// - Control bit 2 sets on timer 0 rollover and stays until software clears it.
// - Control bit 1 sets on an edge-pin event and stays until software clears it.
// - Control bit 0 sets when any of six port pins whose per-pin change enable is set changes; software clears it.
// - Peripheral enables sit at bits 6,5,3,1,0; bits 7,4,2 read zero.
// - Reduced variant drops converter, capture/compare and timer 2 bits; they read zero.
// - Request bit 6 sets when a conversion completes.
// - Request bit 5 sets on capture or compare match, unused in PWM mode.
// - Request bit 3 sets whenever the comparator output changes; software clears it.
// - Request bit 1 sets when timer 2 matches its period; software clears it.
// - Request bit 0 sets when the timer 1 counter overflows; software clears it.
package irq_pkg;

  // ----------------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------------
  localparam logic [1:0] OFS_CONTROL  = 2'h0;
  localparam logic [1:0] OFS_PERIPH_EN = 2'h1;
  localparam logic [1:0] OFS_PERIPH_FL = 2'h2;

  // ----------------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------------
  localparam int BIT_GLOBAL    = 7;
  localparam int BIT_PGROUP    = 6;
  localparam int BIT_T0_EN     = 5;
  localparam int BIT_EDGE_EN   = 4;
  localparam int BIT_PORT_EN   = 3;
  localparam int BIT_T0_FLAG   = 2;
  localparam int BIT_EDGE_FLAG = 1;
  localparam int BIT_PORT_FLAG = 0;
  localparam int BIT_CONV      = 6;
  localparam int BIT_CCP       = 5;
  localparam int BIT_CMP       = 3;
  localparam int BIT_T2        = 1;
  localparam int BIT_T1        = 0;

  // Implemented peripheral bits for the full and the reduced variant.
  localparam logic [7:0] PERIPH_MASK_FULL    = 8'h6b;
  localparam logic [7:0] PERIPH_MASK_REDUCED = 8'h09;
  localparam logic [7:0] RESET_VALUE         = 8'h00;
  localparam int         PORT_PINS           = 6;

  // ----------------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CCP_OFF,
    CCP_CAPTURE,
    CCP_COMPARE,
    CCP_PWM
  } ccp_mode_t;

  typedef struct packed {
    logic      timer0_rollover;
    logic      edge_pin_event;
    logic      conv_done;
    logic      ccp_capture;
    logic      ccp_compare;
    ccp_mode_t ccp_mode;
    logic      comparator_out;
    logic      timer2_match;
    logic      timer1_overflow;
  } irq_events_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage : irq_pkg

// ===== design/port_change_detect.sv
// Port change detector: reports any enabled pin that differs from its last sampled level.
`timescale 1ns/10ps
module port_change_detect #(
  parameter int PINS = irq_pkg::PORT_PINS
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            sys_rst,
  // Pins and per-pin enables
  input  wire logic [PINS-1:0] port_pins,
  input  wire logic [PINS-1:0] per_pin_change_enables,
  // Result
  output logic                 change_pulse
);

  typedef struct packed {
    logic [PINS-1:0] last;
    logic            primed;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // The first sample after reset only primes the reference so reset itself is no change.
  always_comb begin
    state_nxt        = state_r;
    state_nxt.last   = port_pins;
    state_nxt.primed = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign change_pulse = state_r.primed & |((port_pins ^ state_r.last) & per_pin_change_enables);

endmodule : port_change_detect

// ===== design/edge_sense.sv
// Edge detector for a level input, giving a one-cycle pulse on each change to one (rise) and on each change either way (toggle).
`timescale 1ns/10ps
module edge_sense (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Level in, pulses out
  input  wire logic level,
  output logic      rise,
  output logic      toggle
);

  typedef struct packed {
    logic last;
    logic primed;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  always_comb begin
    state_nxt        = state_r;
    state_nxt.last   = level;
    state_nxt.primed = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rise   = state_r.primed & level & ~state_r.last;
  assign toggle = state_r.primed & (level ^ state_r.last);

endmodule : edge_sense

// ===== design/irq_flag_unit.sv
// Interrupt enable and flag unit: control, peripheral enable and peripheral request registers.
`timescale 1ns/10ps
module irq_flag_unit #(
  parameter bit REDUCED = 1'b0,
  parameter int PINS    = irq_pkg::PORT_PINS
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // Register port
  input  wire irq_pkg::reg_req_t  req,
  output logic [7:0]              rdata,
  // Event sources
  input  wire irq_pkg::irq_events_t events,
  input  wire logic [PINS-1:0]    port_pins,
  input  wire logic [PINS-1:0]    per_pin_change_enables,
  // Core request
  output logic                    irq
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] pen;
    logic [7:0] pfl;
    logic [7:0] rdata;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  logic       port_change;
  logic       cmp_change;
  logic [7:0] pmask;
  logic [7:0] core_set;
  logic [7:0] per_set;
  logic       core_pend;
  logic       per_pend;

  // Unimplemented bits read zero; the reduced variant keeps only comparator and timer 1.
  assign pmask = REDUCED ? irq_pkg::PERIPH_MASK_REDUCED : irq_pkg::PERIPH_MASK_FULL;

  port_change_detect #(
    .PINS(PINS)
  ) u_port (
    .clk                    (clk),
    .sys_rst                (sys_rst),
    .port_pins              (port_pins),
    .per_pin_change_enables (per_pin_change_enables),
    .change_pulse           (port_change)
  );

  edge_sense u_cmp (
    .clk     (clk),
    .sys_rst (sys_rst),
    .level   (events.comparator_out),
    .rise    (),
    .toggle  (cmp_change)
  );

  // ----------------------------------------------------------------------------
  // Set terms
  // ----------------------------------------------------------------------------
  // Set terms ignore every register enable but not the per-pin change enables, so software can poll flags with interrupts off.
  always_comb begin
    core_set = 8'h00;
    core_set[irq_pkg::BIT_T0_FLAG]   = events.timer0_rollover;
    core_set[irq_pkg::BIT_EDGE_FLAG] = events.edge_pin_event;
    core_set[irq_pkg::BIT_PORT_FLAG] = port_change;
    per_set = 8'h00;
    per_set[irq_pkg::BIT_CONV] = events.conv_done;
    per_set[irq_pkg::BIT_CCP]  = (events.ccp_mode == irq_pkg::CCP_CAPTURE && events.ccp_capture) ||
                                 (events.ccp_mode == irq_pkg::CCP_COMPARE && events.ccp_compare);
    per_set[irq_pkg::BIT_CMP]  = cmp_change;
    per_set[irq_pkg::BIT_T2]   = events.timer2_match;
    per_set[irq_pkg::BIT_T1]   = events.timer1_overflow;
    per_set = per_set & pmask;
  end

  // ----------------------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------------------
  // A hardware set in the same cycle as a software write wins, so no event is lost.
  always_comb begin
    state_nxt = state_r;
    if (req.wr) begin
      case (req.addr)
        irq_pkg::OFS_CONTROL: begin
          state_nxt.ctrl = req.wdata;
        end
        irq_pkg::OFS_PERIPH_EN: begin
          state_nxt.pen = req.wdata & pmask;
        end
        irq_pkg::OFS_PERIPH_FL: begin
          state_nxt.pfl = req.wdata & pmask;
        end
        default: begin
        end
      endcase
    end
    state_nxt.ctrl = state_nxt.ctrl | core_set;
    state_nxt.pfl  = state_nxt.pfl | per_set;
    state_nxt.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        irq_pkg::OFS_CONTROL: begin
          state_nxt.rdata = state_r.ctrl;
        end
        irq_pkg::OFS_PERIPH_EN: begin
          state_nxt.rdata = state_r.pen & pmask;
        end
        irq_pkg::OFS_PERIPH_FL: begin
          state_nxt.rdata = state_r.pfl & pmask;
        end
        default: begin
          state_nxt.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= {4{irq_pkg::RESET_VALUE}};
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Request to the core
  // ----------------------------------------------------------------------------
  assign core_pend = (state_r.ctrl[irq_pkg::BIT_T0_EN]   & state_r.ctrl[irq_pkg::BIT_T0_FLAG])   |
                     (state_r.ctrl[irq_pkg::BIT_EDGE_EN] & state_r.ctrl[irq_pkg::BIT_EDGE_FLAG]) |
                     (state_r.ctrl[irq_pkg::BIT_PORT_EN] & state_r.ctrl[irq_pkg::BIT_PORT_FLAG]);
  assign per_pend  = state_r.ctrl[irq_pkg::BIT_PGROUP] & |(state_r.pen & state_r.pfl & pmask);
  assign irq       = state_r.ctrl[irq_pkg::BIT_GLOBAL] & (core_pend | per_pend);
  assign rdata     = state_r.rdata;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  property p_flag_sets_always;
    @(posedge clk) disable iff (sys_rst)
      events.timer0_rollover |=> state_r.ctrl[irq_pkg::BIT_T0_FLAG];
  endproperty
  a_flag_sets_always: assert property (p_flag_sets_always) else $error("Timer 0 flag missed its event.");

  property p_global_blocks;
    @(posedge clk) disable iff (sys_rst)
      !state_r.ctrl[irq_pkg::BIT_GLOBAL] |-> !irq;
  endproperty
  a_global_blocks: assert property (p_global_blocks) else $error("Request with global enable clear.");

  property p_group_blocks;
    @(posedge clk) disable iff (sys_rst)
      (!state_r.ctrl[irq_pkg::BIT_PGROUP] && (state_r.ctrl[5:3] & state_r.ctrl[2:0]) == 3'h0) |-> !irq;
  endproperty
  a_group_blocks: assert property (p_group_blocks) else $error("Peripheral request with group enable clear.");

  property p_t0_gate;
    @(posedge clk) disable iff (sys_rst)
      (state_r.ctrl == 8'ha4) |-> irq;
  endproperty
  a_t0_gate: assert property (p_t0_gate) else $error("Timer 0 interrupt not raised.");

  property p_edge_gate;
    @(posedge clk) disable iff (sys_rst)
      (state_r.ctrl[7:0] == 8'h82 && !per_pend) |-> !irq;
  endproperty
  a_edge_gate: assert property (p_edge_gate) else $error("Edge interrupt raised while disabled.");

  property p_flag_sticky;
    @(posedge clk) disable iff (sys_rst)
      (state_r.ctrl[irq_pkg::BIT_T0_FLAG] && !(req.wr && req.addr == irq_pkg::OFS_CONTROL)) |=>
        state_r.ctrl[irq_pkg::BIT_T0_FLAG];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("Timer 0 flag dropped without a write.");

  property p_edge_flag;
    @(posedge clk) disable iff (sys_rst)
      events.edge_pin_event |=> state_r.ctrl[irq_pkg::BIT_EDGE_FLAG];
  endproperty
  a_edge_flag: assert property (p_edge_flag) else $error("Edge flag missed its event.");

  property p_reserved_zero;
    @(posedge clk) disable iff (sys_rst)
      $past(req.rd) && $past(req.addr) != irq_pkg::OFS_CONTROL |-> (rdata & ~pmask) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Unimplemented bit read nonzero.");

  property p_cmp_flag;
    @(posedge clk) disable iff (sys_rst)
      cmp_change |=> state_r.pfl[irq_pkg::BIT_CMP];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("Comparator flag missed a change.");

  property p_t1_flag;
    @(posedge clk) disable iff (sys_rst)
      events.timer1_overflow |=> state_r.pfl[irq_pkg::BIT_T1] ##1
        (state_r.pfl[irq_pkg::BIT_T1] || $past(req.wr && req.addr == irq_pkg::OFS_PERIPH_FL));
  endproperty
  a_t1_flag: assert property (p_t1_flag) else $error("Timer 1 flag not held.");

  // Covers for the main scenarios: core and peripheral requests, set against clear, flag clears.
  c_irq_core: cover property (@(posedge clk) disable iff (sys_rst) !irq ##1 irq && core_pend);
  c_port_flag: cover property (@(posedge clk) disable iff (sys_rst) port_change);
  c_t1_clear: cover property (@(posedge clk) disable iff (sys_rst)
    state_r.pfl[irq_pkg::BIT_T1] ##1 !state_r.pfl[irq_pkg::BIT_T1]);
  c_irq_per: cover property (@(posedge clk) disable iff (sys_rst) !irq ##1 irq && per_pend);
  c_set_wins: cover property (@(posedge clk) disable iff (sys_rst) req.wr && |core_set);

endmodule : irq_flag_unit

// ===== sim/event_source_model.sv
// Model of the timers, converter, capture unit and comparator that raise events.
`timescale 1ns/10ps
module event_source_model (
  // Clock
  input  wire logic               clk,
  // Capture unit mode from the bench
  input  wire irq_pkg::ccp_mode_t mode,
  // Events toward the unit
  output irq_pkg::irq_events_t    events
);
  irq_pkg::irq_events_t ev_r = '0;

  always_comb begin
    events = ev_r;
    events.ccp_mode = mode;
  end

  // Event pulses last one cycle; the comparator is a level that only toggles.
  task automatic pulse(input int k);
    irq_pkg::irq_events_t nx;
    @(posedge clk);
    case (k)
      0: ev_r.timer0_rollover <= 1'b1;
      1: ev_r.edge_pin_event <= 1'b1;
      2: ev_r.conv_done <= 1'b1;
      3: ev_r.ccp_capture <= 1'b1;
      4: ev_r.ccp_compare <= 1'b1;
      5: ev_r.timer2_match <= 1'b1;
      6: ev_r.timer1_overflow <= 1'b1;
      default: ev_r.comparator_out <= ~ev_r.comparator_out;
    endcase
    @(posedge clk);
    nx = '0;
    nx.comparator_out = ev_r.comparator_out;
    ev_r <= nx;
  endtask : pulse
endmodule : event_source_model

// ===== sim/tb_top.sv
// Self-checking bench for the interrupt enable and flag unit.
`timescale 1ns/10ps
module tb_top;
  logic                 clk;
  logic                 sys_rst;
  irq_pkg::reg_req_t    req;
  irq_pkg::ccp_mode_t   mode;
  irq_pkg::irq_events_t events;
  logic [5:0]           port_pins;
  logic [5:0]           per_pin_change_enables;
  logic [7:0]           rdata;
  logic [7:0]           rdata_red;
  logic                 irq;
  logic                 irq_red;
  logic [7:0]           c;
  logic [7:0]           pe;
  logic [7:0]           pf;
  logic [7:0]           q;
  logic [7:0]           qr;
  int                   miscompares;
  int                   tests_run;
  int                   ev_k[10] = '{0, 1, 2, 3, 4, 5, 6, 7, 3, 4};
  logic [1:0]           ev_a[10] = '{2'h0, 2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
  logic [7:0]           ev_v[10] = '{8'h04, 8'h02, 8'h40, 8'h20, 8'h20, 8'h02, 8'h01, 8'h08, 8'h00, 8'h00};
  logic [7:0]           corner[9] = '{8'h7f, 8'hb8, 8'ha4, 8'h92, 8'h89, 8'hc0, 8'ha2, 8'h87, 8'h82};

  irq_flag_unit #(.REDUCED(1'b0), .PINS(6)) u_irq_flag_unit (.clk(clk), .sys_rst(sys_rst), .req(req),
    .rdata(rdata), .events(events), .port_pins(port_pins), .per_pin_change_enables(per_pin_change_enables), .irq(irq));
  irq_flag_unit #(.REDUCED(1'b1), .PINS(6)) u_irq_flag_unit_reduced (.clk(clk), .sys_rst(sys_rst), .req(req),
    .rdata(rdata_red), .events(events), .port_pins(port_pins), .per_pin_change_enables(per_pin_change_enables),
    .irq(irq_red));
  event_source_model u_event_source_model (.clk(clk), .mode(mode), .events(events));

  always #5 clk = ~clk;

  // ----------------------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe is taken.
  task automatic rd(input logic [1:0] a, output logic [7:0] v, output logic [7:0] vr);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    v = rdata;
    vr = rdata_red;
  endtask : rd

  function automatic logic exp_irq(input logic [7:0] cc, input logic [7:0] e, input logic [7:0] f,
                                   input logic [7:0] m);
    logic periph;
    periph = cc[6] & (|(e & f & m));
    return cc[7] & ((cc[5] & cc[2]) | (cc[4] & cc[1]) | (cc[3] & cc[0]) | periph);
  endfunction : exp_irq

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // A hang is cut short and counted as a mismatch.
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    results();
  end

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    req = '0;
    mode = irq_pkg::CCP_CAPTURE;
    port_pins = 6'h00;
    per_pin_change_enables = 6'h3f;
    miscompares = 0;
    tests_run = 0;
    void'($urandom(32'h1ff9));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    wr(2'h3, 8'hff);
    for (int a = 0; a < 4; a++) begin
      rd(a[1:0], q, qr);
      chk(q, 8'h00);
    end
    chk({7'h00, irq}, 8'h00);
    wr(2'h1, 8'hff);
    rd(2'h1, q, qr);
    chk(q, 8'h6b);
    chk(qr, 8'h09);
    wr(2'h1, 8'h00);
    // Every source but port change with all register enables off; the flag must still set and hold.
    // The last two entries raise capture/compare events in PWM and off mode, which must not set.
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      mode <= i == 4 ? irq_pkg::CCP_COMPARE : (i == 8 ? irq_pkg::CCP_PWM :
              (i == 9 ? irq_pkg::CCP_OFF : irq_pkg::CCP_CAPTURE));
      u_event_source_model.pulse(ev_k[i]);
      repeat (2) @(posedge clk);
      rd(ev_a[i], q, qr);
      chk(q, ev_v[i]);
      chk(qr, ev_a[i] == 2'h2 ? (ev_v[i] & 8'h09) : ev_v[i]);
      wr(ev_a[i], 8'h00);
      rd(ev_a[i], q, qr);
      chk(q, 8'h00);
    end
    for (int p = 0; p < 6; p++) begin
      @(posedge clk);
      per_pin_change_enables <= 6'h3f ^ (6'h01 << p);
      @(posedge clk);
      port_pins[p] <= ~port_pins[p];
      repeat (3) @(posedge clk);
      rd(2'h0, q, qr);
      chk(q, 8'h00);
      @(posedge clk);
      per_pin_change_enables <= 6'h3f;
      repeat (2) @(posedge clk);
      port_pins[p] <= ~port_pins[p];
      repeat (3) @(posedge clk);
      rd(2'h0, q, qr);
      chk(q, 8'h01);
      wr(2'h0, 8'h00);
    end
    // A flag event in the cycle of a clearing write must win over the clear.
    fork
      u_event_source_model.pulse(0);
      wr(2'h0, 8'h00);
    join
    rd(2'h0, q, qr);
    chk(q, 8'h04);
    wr(2'h0, 8'h00);
    // Interrupt gating: corner settings first, then random ones.
    for (int n = 0; n < 200; n++) begin
      c = n < 9 ? corner[n] : 8'($urandom);
      pe = n < 9 ? 8'hff : 8'($urandom);
      pf = n < 9 ? 8'hff : 8'($urandom);
      wr(2'h2, pf);
      wr(2'h1, pe);
      wr(2'h0, c);
      #1;
      chk({7'h00, irq}, {7'h00, exp_irq(c, pe, pf, 8'h6b)});
      chk({7'h00, irq_red}, {7'h00, exp_irq(c, pe, pf, 8'h09)});
      rd(2'h2, q, qr);
      chk(q, pf & 8'h6b);
      chk(qr, pf & 8'h09);
      rd(2'h0, q, qr);
      chk(q, c);
    end
    // A reset in mid-run must clear every register and drop the request.
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 3; a++) begin
      rd(a[1:0], q, qr);
      chk(q, 8'h00);
      chk(qr, 8'h00);
    end
    chk({7'h00, irq}, 8'h00);
    chk({7'h00, irq_red}, 8'h00);
    results();
  end
endmodule : tb_top
